// ===== design/ase_pkg.sv
// constants for the amplitude step encoder
package ase_pkg;
   localparam int WORD_W      = 12;
   localparam int COARSE_W    = 7;
   localparam int FINE_W      = 5;
   localparam int ADDR_W      = 8;
   localparam int ROM_W       = 8;
   localparam int ROM_COUNT   = 8;
   localparam int COARSE_MAX  = 123;
   localparam int AMP_COUNT   = 128;
   localparam int LOWER_LO    = 0;
   localparam int LOWER_HI    = 31;
   localparam int UPPER_LO    = 96;
   localparam int UPPER_HI    = 122;
   localparam int MID_LO      = 32;
   localparam int MID_HI      = 95;
   localparam int INST_A_W    = 64;
   localparam int INST_B_W    = 64;
   localparam logic [WORD_W-1:0] WORD_RESET = 12'h000;
endpackage

// ===== design/ase_amplitude_step_encoder.sv
// amplitude step encoder: word capture, coarse lookup decode and fine steps
// What this block does
// - input is a stream of 12-bit words, word_msb first, word_lsb last
// - upper seven bits drive coarse steps, lower five bits drive fine steps
// - coarse amplifiers on equals unsigned value of upper seven bits, saturating at 123
// - each fine output follows its own word bit directly
// - eight fixed 256x8 lookup tables per encoder instance decode coarse steps
// - every lookup table is addressed by the eight top word bits
// - each lookup output bit controls one coarse amplifier, except board a's top five bits, which the fine steps replace
// - instance A: coarse 1-32, 97-123 and fine; instance B: coarse 33-96
// - one on/off output for each of 128 amplifiers
// - word registers capture on falling edge of their capture clock
// - active-low sample strobe is inverted; capture on its release high
// - outputs hold until next strobe or clear
// - clear forces every output low, all amplifiers off
// - kill asserted on interlock, power-up reset, fault, monitor or converter off
`timescale 1ns/1ps

module ase_amplitude_step_encoder
(
   // clock and reset
   input  wire logic                         mclk,
   input  wire logic                         rst,
   // converter word and strobe
   input  wire logic [ase_pkg::WORD_W-1:0]   audioWord,
   input  wire logic                         sampleStrobe_n,
   // kill sources, all active low
   input  wire logic                         cableInterlock_n,
   input  wire logic                         powerup_reset_n,
   input  wire logic                         faultTurnOff_n,
   input  wire logic                         monitorTurnOff_n,
   input  wire logic                         converterTurnOff_n,
   // amplifier controls
   output logic [ase_pkg::AMP_COUNT-1:0]     ampOn,
   output logic [ase_pkg::INST_A_W-1:0]      instAOn,
   output logic [ase_pkg::INST_B_W-1:0]      instBOn,
   output logic                              amp_disable_n
);

   // word bit 11 is word_msb, bit 0 is word_lsb
   logic [ase_pkg::WORD_W-1:0]               word_q, word_d;
   logic                                     strobeInv_q, strobeInv_d;
   logic                                     output_kill_n;
   logic                                     killReg_q, killReg_d;
   logic [ase_pkg::ADDR_W-1:0]               romAddr;
   logic [ase_pkg::FINE_W-1:0]               fineVal;
   logic [ase_pkg::INST_A_W-1:0]             stepsA;
   logic [ase_pkg::INST_B_W-1:0]             stepsB;

   // any low source drops the kill for both boards
   ase_kill_merge
   #(
      .SOURCES (5)
   )
   uKill
   (
      .source_n     ({converterTurnOff_n, monitorTurnOff_n, faultTurnOff_n,
                      powerup_reset_n, cableInterlock_n}),
      .killMerged_n (output_kill_n)
   );

   // inverted strobe forms the capture clock, sampled in the mclk domain
   always_comb
   begin
      strobeInv_d = ~sampleStrobe_n;
      word_d      = word_q;
      killReg_d   = output_kill_n;
      // falling edge of inverted strobe is the release of the active-low strobe
      if (!output_kill_n)
      begin
         word_d = ase_pkg::WORD_RESET;
      end
      else if (strobeInv_q && sampleStrobe_n)
      begin
         word_d = audioWord;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         word_q      <= ase_pkg::WORD_RESET;
         strobeInv_q <= 1'b0;
         killReg_q   <= 1'b0;
      end
      else
      begin
         word_q      <= word_d;
         strobeInv_q <= strobeInv_d;
         killReg_q   <= killReg_d;
      end
   end

   // coarse count is romAddr[7:1]; word bit 4 only changes the fine half step
   assign romAddr = word_q[ase_pkg::WORD_W-1 -: ase_pkg::ADDR_W];
   assign fineVal = word_q[ase_pkg::FINE_W-1:0];

   // step numbering: coarse step n is amp index n-1; fine steps are 123..127
   // board a: steps 1..32 and 97..123, plus the five fine steps
   ase_encoder_half
   #(
      .LOW_BASE  (ase_pkg::LOWER_LO),
      .HIGH_BASE (ase_pkg::UPPER_LO),
      .HAS_FINE  (1'b1)
   )
   uBoardA
   (
      .mclk    (mclk),
      .rst     (rst),
      .addr    (romAddr),
      .fine    (fineVal),
      .clear_n (output_kill_n),
      .steps   (stepsA)
   );

   // board b: steps 33..96 only; its fine input is ignored
   ase_encoder_half
   #(
      .LOW_BASE  (ase_pkg::MID_LO),
      .HIGH_BASE (ase_pkg::MID_LO + ase_pkg::INST_B_W / 2),
      .HAS_FINE  (1'b0)
   )
   uBoardB
   (
      .mclk    (mclk),
      .rst     (rst),
      .addr    (romAddr),
      .fine    (fineVal),
      .clear_n (output_kill_n),
      .steps   (stepsB)
   );

   // both boards register their steps, so each output bit comes from a flip-flop
   assign ampOn = {stepsA[ase_pkg::INST_A_W-1 -: ase_pkg::AMP_COUNT - ase_pkg::UPPER_LO],
                   stepsB,
                   stepsA[ase_pkg::LOWER_HI:ase_pkg::LOWER_LO]};
   assign instAOn       = stepsA;
   assign instBOn       = stepsB;
   assign amp_disable_n = killReg_q;

endmodule // ase_amplitude_step_encoder

// one fixed 256x8 thermometer table; count is address bits 7..1
module ase_step_rom
#(
   parameter int BASE = 0
)
(
   // lookup port
   input  wire logic [ase_pkg::ADDR_W-1:0]   addr,
   output logic [ase_pkg::ROM_W-1:0]         data
);
   logic [ase_pkg::ROM_W-1:0] table_c [0:(1<<ase_pkg::ADDR_W)-1];

   // contents are constant; a synthesiser folds them into logic
   always_comb
   begin
      for (int a = 0; a < (1 << ase_pkg::ADDR_W); a++)
      begin
         for (int b = 0; b < ase_pkg::ROM_W; b++)
         begin
            table_c[a][b] = ((a >> 1) > (BASE + b));
         end
      end
      data = table_c[addr];
   end
endmodule // ase_step_rom

// one encoder board: eight fixed tables feeding a cleared output register
// tables 0..3 start at LOW_BASE, tables 4..7 at HIGH_BASE
module ase_encoder_half
#(
   parameter int LOW_BASE  = 0,
   parameter int HIGH_BASE = 32,
   parameter bit HAS_FINE  = 1'b0
)
(
   // clock and reset
   input  wire logic                                      mclk,
   input  wire logic                                      rst,
   // word fields and clear
   input  wire logic [ase_pkg::ADDR_W-1:0]                addr,
   input  wire logic [ase_pkg::FINE_W-1:0]                fine,
   input  wire logic                                      clear_n,
   // registered board outputs
   output logic [ase_pkg::ROM_COUNT*ase_pkg::ROM_W-1:0]   steps
);
   localparam int HALF_ROMS = ase_pkg::ROM_COUNT / 2;
   localparam int BOARD_W   = ase_pkg::ROM_COUNT * ase_pkg::ROM_W;
   // fine steps take the top five board bits; only valid for board a's layout
   localparam int FINE_POS  = BOARD_W - ase_pkg::FINE_W;

   logic [BOARD_W-1:0] romOut;
   logic [BOARD_W-1:0] steps_q, steps_d;

   genvar t;
   generate
      for (t = 0; t < ase_pkg::ROM_COUNT; t++)
      begin : gTable
         localparam int BASE = (t < HALF_ROMS) ? LOW_BASE + t * ase_pkg::ROM_W
                                               : HIGH_BASE + (t - HALF_ROMS) * ase_pkg::ROM_W;
         ase_step_rom #(.BASE(BASE)) uRom
         (
            .addr (addr),
            .data (romOut[t*ase_pkg::ROM_W +: ase_pkg::ROM_W])
         );
      end
   endgenerate

   // table bits above step 123 are unused; the fine steps replace them
   always_comb
   begin
      steps_d = romOut;
      if (HAS_FINE)
      begin
         for (int j = 0; j < ase_pkg::FINE_W; j++)
         begin
            steps_d[FINE_POS + j] = fine[ase_pkg::FINE_W-1-j];
         end
      end
      if (!clear_n)
      begin
         steps_d = '0;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         steps_q <= '0;
      end
      else
      begin
         steps_q <= steps_d;
      end
   end

   assign steps = steps_q;
endmodule // ase_encoder_half

// merges active-low kill sources; any one low kills every output
module ase_kill_merge
#(
   parameter int SOURCES = 5
)
(
   // kill sources and merged result
   input  wire logic [SOURCES-1:0]   source_n,
   output logic                      killMerged_n
);
   always_comb
   begin
      killMerged_n = &source_n;
   end
endmodule // ase_kill_merge

// ===== bench/ase_step_properties.sv
// port assertions for the amplitude step encoder
`timescale 1ns/1ps
module ase_step_properties
(
   // watched ports
   input wire logic         mclk,
   input wire logic         rst,
   input wire logic [11:0]  audioWord,
   input wire logic         sampleStrobe_n,
   input wire logic         cableInterlock_n,
   input wire logic         powerup_reset_n,
   input wire logic         faultTurnOff_n,
   input wire logic         monitorTurnOff_n,
   input wire logic         converterTurnOff_n,
   input wire logic [127:0] ampOn,
   input wire logic [63:0]  instAOn,
   input wire logic [63:0]  instBOn,
   input wire logic         amp_disable_n
);
   wire logic kOk = cableInterlock_n & powerup_reset_n & faultTurnOff_n & monitorTurnOff_n
      & converterTurnOff_n;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // one settled cycle after capture, so either pipeline depth is judged fairly
   sequence capt_s;
      !sampleStrobe_n && kOk ##1 sampleStrobe_n && kOk ##1 sampleStrobe_n && kOk;
   endsequence
   inst_a_map_a: assert property (instAOn == {ampOn[127:96], ampOn[31:0]})
      else $error("instance a map wrong");
   inst_b_map_a: assert property (instBOn == ampOn[95:32])
      else $error("instance b map wrong");
   coarse_count_a: assert property (capt_s |=> ampOn[122:0] == (123'h1 << $past(audioWord[11:5], 2)) - 123'h1)
      else $error("coarse steps wrong");
   fine_steps_a: assert property (capt_s |=> ampOn[127:123] == {$past(audioWord[0], 2),
      $past(audioWord[1], 2), $past(audioWord[2], 2), $past(audioWord[3], 2),
      $past(audioWord[4], 2)})
      else $error("fine steps wrong");
   kill_clear_a: assert property (!kOk ##1 !kOk |=> ampOn == 128'h0 && !amp_disable_n)
      else $error("kill did not clear");
   quiet_hold_a: assert property ((sampleStrobe_n && kOk)[*3] |=> $stable(ampOn))
      else $error("outputs moved");
   disable_up_a: assert property (kOk[*2] |=> amp_disable_n)
      else $error("disable stuck low");
   reset_clear_a: assert property (disable iff (1'b0) rst |=> ampOn == 128'h0 && !amp_disable_n)
      else $error("reset did not clear");
endmodule // ase_step_properties
bind ase_amplitude_step_encoder ase_step_properties chk (.*);

// ===== bench/ase_converter_model.sv
// converter board model: words with the active-low sample strobe
`timescale 1ns/1ps
module ase_converter_model
(
   // converter side
   input  wire logic   mclk,
   output logic [11:0] audioWord,
   output logic        sampleStrobe_n
);
   initial
   begin
      audioWord = 12'h555;
      sampleStrobe_n = 1'b1;
   end
   // word is inverted outside its capture cycle so a stale value never matches
   task automatic send(input logic [11:0] w);
      @(posedge mclk);
      #1 sampleStrobe_n = 1'b0;
      audioWord = ~w;
      @(posedge mclk);
      #1 sampleStrobe_n = 1'b1;
      audioWord = w;
      @(posedge mclk);
      #1 audioWord = ~w;
   endtask
endmodule // ase_converter_model

// ===== bench/amplitude_step_encoder_bench.sv
// self-checking bench for the amplitude step encoder
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
   $display("wrong value at %0t: %h %h", $time, a, b); end end
module amplitude_step_encoder_bench;
   logic         mclk;
   logic         rst;
   logic [4:0]   killN;
   logic [11:0]  audioWord;
   logic         sampleStrobe_n;
   logic [127:0] ampOn;
   logic [63:0]  instAOn;
   logic [63:0]  instBOn;
   logic         amp_disable_n;
   int           fail_count = 0;
   int           checks = 0;
   ase_converter_model conv (.mclk(mclk), .audioWord(audioWord), .sampleStrobe_n(sampleStrobe_n));
   ase_amplitude_step_encoder uut (.mclk(mclk), .rst(rst), .audioWord(audioWord),
      .sampleStrobe_n(sampleStrobe_n), .cableInterlock_n(killN[0]), .powerup_reset_n(killN[1]),
      .faultTurnOff_n(killN[2]), .monitorTurnOff_n(killN[3]), .converterTurnOff_n(killN[4]),
      .ampOn(ampOn), .instAOn(instAOn), .instBOn(instBOn), .amp_disable_n(amp_disable_n));
   function automatic logic [127:0] expOn(logic [11:0] w);
      return {w[0], w[1], w[2], w[3], w[4], (123'h1 << w[11:5]) - 123'h1};
   endfunction
   task automatic step;
      @(posedge mclk);
      #1;
   endtask
   // every board boundary, the end of the coarse steps and the saturated top
   task automatic word_table;
      logic [11:0]  w [15] = '{12'h000, 12'hfff, 12'h5eb, 12'h7e0, 12'h820, 12'h01f,
                               12'h3e0, 12'h400, 12'h420, 12'h800, 12'hc00, 12'hc20,
                               12'hf40, 12'hf60, 12'hf80};
      logic [127:0] e;
      foreach (w[i])
      begin
         e = expOn(w[i]);
         conv.send(w[i]);
         step();
         `CHK(ampOn, e)
         `CHK({instAOn, instBOn}, {e[127:96], e[31:0], e[95:32]})
         repeat (3) step();
         `CHK(ampOn, e)
      end
   endtask
   task automatic kill_each;
      for (int i = 0; i < 5; i++)
      begin
         conv.send(12'h9a5);
         killN[i] = 1'b0;
         step();
         step();
         `CHK({amp_disable_n, ampOn}, 129'h0)
         conv.send(12'h3c7);
         step();
         `CHK(ampOn, 128'h0)
         killN = 5'h1f;
         step();
         step();
         `CHK({amp_disable_n, ampOn}, {1'b1, 128'h0})
      end
   endtask
   task automatic reset_check;
      `CHK({amp_disable_n, ampOn}, 129'h0)
   endtask
   task automatic finish_test;
      if (fail_count == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   initial
   begin
      rst = 1'b1;
      killN = 5'h1f;
      repeat (6) @(posedge mclk);
      #1 rst = 1'b0;
      reset_check();
      word_table();
      kill_each();
      finish_test();
   end
   initial
   begin
      #20000;
      fail_count++;
      finish_test();
   end
endmodule // amplitude_step_encoder_bench
